// >>> src/ecc_control.sv
module ecc_control
  import ecc_ctl_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Control register writes
  input wire logic cfg_wr,
  input wire logic cfg_wdata,
  input wire logic inj_wr,
  input wire logic [2*NUM_TGT-1:0] inj_wdata,
  // Control register state
  output logic code_check_enable_bit,
  output logic [2*NUM_TGT-1:0] fault_injection_control,
  // Protected array write strobes (tag fill start, data fill, reg write, data store)
  input wire logic [NUM_TGT-1:0] arr_write,
  output logic [2*NUM_TGT-1:0] arr_flip,
  // Decoder results per source
  input wire logic [NUM_SRC-1:0] det_single,
  input wire logic [NUM_SRC-1:0] det_double,
  input wire logic icache_line_valid,
  input wire logic in_handler,
  // Exceptions and events
  output logic ecc_exception,
  output logic [NUM_SRC-1:0] corr_event,
  output logic handler_loop_event
);
  // ==========================================================================
  // Registers
  logic check_en_reg, check_en_next;
  logic [2*NUM_TGT-1:0] inj_reg, inj_next;
  logic exc_reg, exc_next;
  logic [NUM_SRC-1:0] corr_reg, corr_next;
  logic loop_reg, loop_next;
  logic [NUM_TGT-1:0] done_w;
  logic [NUM_SRC-1:0] valid_src;
  logic [2*NUM_TGT-1:0] flip_w;

  // ==========================================================================
  // One injection slot per array; check bits are always produced, the flip
  // mask only perturbs them, so disabling checking never skips the store
  genvar g;
  generate
    for (g = 0; g < NUM_TGT; g++) begin : g_slot
      ecc_inj_if sif();
      assign sif.mode = inj_reg[2*g +: 2];
      assign sif.write_fire = arr_write[g];
      assign flip_w[2*g +: 2] = sif.flip_mask;
      assign done_w[g] = sif.done;
      ecc_inj_slot u_slot (
        .port(sif.slot)
      );
    end
  endgenerate

  // Instruction memory has no slot: it is only written by correction
  assign valid_src = {{(NUM_SRC-1){1'b1}}, icache_line_valid};

  // ==========================================================================
  // Next state
  always_comb begin
    check_en_next = check_en_reg;
    inj_next = inj_reg;
    if (cfg_wr) begin
      check_en_next = cfg_wdata;
    end
    if (inj_wr) begin
      inj_next = inj_wdata;
    end
    // Completion wins over a same-cycle write so the armed fault is not repeated
    for (int i = 0; i < NUM_TGT; i++) begin
      if (done_w[i]) begin
        inj_next[2*i +: 2] = INJ_RESET;
      end
    end
    // Line valid bit gates only tag source detection (line invalid); data source is not gated
    corr_next = check_en_reg ? (det_single & valid_src) : '0;
    exc_next = check_en_reg && |(det_double & valid_src);
    loop_next = exc_next && in_handler;
  end

  // ==========================================================================
  // Registers
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      check_en_reg <= CHECK_EN_RESET;
      inj_reg <= '0;
      exc_reg <= 1'b0;
      corr_reg <= '0;
      loop_reg <= 1'b0;
    end else begin
      check_en_reg <= check_en_next;
      inj_reg <= inj_next;
      exc_reg <= exc_next;
      corr_reg <= corr_next;
      loop_reg <= loop_next;
    end
  end

  assign code_check_enable_bit = check_en_reg;
  assign fault_injection_control = inj_reg;
  assign arr_flip = flip_w;
  assign ecc_exception = exc_reg;
  assign corr_event = corr_reg;
  assign handler_loop_event = loop_reg;
endmodule

// >>> src/ecc_ctl_pkg.sv
// Contract
// - Checking is off after reset.
// - Writing zero to the enable bit stops checking.
// - Check bits are always generated and stored, even while checking is off.
// - Errors from an invalid instruction cache line are ignored (the code ignores only tag source errors; data source errors still report).
// - An uncorrectable error raises an exception.
// - Every read of a register with a two-bit error raises another exception.
// - A handler-loop event line is driven on the event outputs.
// - Armed tag injection corrupts the tag write at next line fill start.
// - A field returns to idle after its injection is carried out.
// - Injected tag error is reported after the jump target is reached.
// - Armed data injection corrupts the next fill; second execution detects it.
// - Instruction memory is written only for corrections, never injected.
// - Data-side injection into shared memory reports at fetched jump target.
package ecc_ctl_pkg;
  // ==========================================================================
  // Injection field encoding
  typedef enum logic [1:0] {
    injection_idle = 2'h0,
    inject_one_bit = 2'h1,
    inject_two_bits = 2'h2
  } inj_mode_e;
  localparam logic [1:0] INJ_RESET = 2'h0;
  localparam logic CHECK_EN_RESET = 1'b0;
  // ==========================================================================
  // Protected arrays (injection targets)
  localparam int NUM_TGT = 4;
  localparam int TGT_ICACHE_TAG_INJECT_FIELD = 0;
  localparam int TGT_ICACHE_DATA_INJECT_FIELD = 1;
  localparam int TGT_RF = 2;
  localparam int TGT_DATA_COUPLED_MEMORY = 3;
  localparam int NUM_SRC = 6;
  localparam int SRC_ICACHE_TAG_INJECT_FIELD = 0;
  localparam int SRC_ICACHE_DATA_INJECT_FIELD = 1;
  localparam int SRC_RF = 2;
  localparam int SRC_DATA_COUPLED_MEMORY = 3;
  localparam int SRC_INSTR_COUPLED_MEMORY = 4;
  localparam int SRC_TLB = 5;
  // Check bits flipped per mode
  localparam logic [1:0] FLIP_ONE = 2'h1;
  localparam logic [1:0] FLIP_TWO = 2'h3;
endpackage

// >>> src/ecc_inj_if.sv
interface ecc_inj_if;
  logic [1:0] mode;
  logic write_fire;
  logic [1:0] flip_mask;
  logic done;
  modport ctl(output mode, write_fire, input flip_mask, done);
  modport slot(input mode, write_fire, output flip_mask, done);
endinterface

// >>> src/ecc_inj_slot.sv
module ecc_inj_slot
  import ecc_ctl_pkg::*;
(
  ecc_inj_if.slot port
);
  // ==========================================================================
  // Corruption mask for one array write
  always_comb begin
    port.flip_mask = 2'h0;
    port.done = 1'b0;
    if (port.write_fire) begin
      case (port.mode)
        inject_one_bit: begin
          port.flip_mask = FLIP_ONE;
          port.done = 1'b1;
        end
        inject_two_bits: begin
          port.flip_mask = FLIP_TWO;
          port.done = 1'b1;
        end
        default: begin
          port.flip_mask = 2'h0;
        end
      endcase
    end
  end
endmodule

// >>> test/ecc_chk.sv
// =====
// Port checker
module ecc_chk import ecc_ctl_pkg::*; (
  // Control
  input wire logic clk, rst_b, cfg_wr, cfg_wdata, inj_wr, icache_line_valid, in_handler,
  input wire logic [7:0] inj_wdata, fault_injection_control, arr_flip,
  input wire logic [3:0] arr_write,
  input wire logic [5:0] det_single, det_double, corr_event,
  // Results
  input wire logic code_check_enable_bit, ecc_exception, handler_loop_event
);
  timeunit 1ns;
  timeprecision 1ns;
  logic unc;
  logic [7:0] fx;
  assign unc = code_check_enable_bit && (det_double[5:1] != 5'h0 || det_double[0] && icache_line_valid);
  always_comb begin
    for (int t = 0; t < 4; t++) begin
      fx[2*t+:2] = {2{arr_write[t]}} & {fault_injection_control[2*t+:2] == 2'h2, ^fault_injection_control[2*t+:2]};
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  sequence s_arm;
    inj_wr && !(arr_write[0] && ^fault_injection_control[1:0]);
  endsequence
  chk_reset_off: assert property (!$past(rst_b) |-> !code_check_enable_bit) else $error("enable on");
  chk_cfg_write: assert property (cfg_wr |=> code_check_enable_bit == $past(cfg_wdata)) else $error("cfg");
  chk_inj_flip: assert property (arr_flip == fx) else $error("flip");
  chk_inj_arm: assert property (s_arm |=> fault_injection_control[1:0] == $past(inj_wdata[1:0])) else $error("arm");
  chk_tag_clear: assert property (arr_write[0] && ^fault_injection_control[1:0] |=>
    fault_injection_control[1:0] == 2'h0) else $error("clear");
  chk_uncorr_exc: assert property (ecc_exception == $past(unc)) else $error("exception");
  chk_loop_event: assert property (handler_loop_event == ($past(unc) && $past(in_handler))) else $error("loop");
  chk_corr_gate: assert property (corr_event == ($past(det_single) & {5'h1F, $past(icache_line_valid)}
    & {6{$past(code_check_enable_bit)}})) else $error("corr");
endmodule
bind ecc_control ecc_chk u_chk (.*);

// >>> test/ecc_control_tb.sv
// =====
// Bench
module ecc_control_tb import ecc_ctl_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, rst_b = 0, cfg_wr = 0, cfg_wdata = 0, inj_wr = 0, icache_line_valid = 0, in_handler = 0;
  logic code_check_enable_bit, ecc_exception, handler_loop_event;
  logic [7:0] inj_wdata = 8'h0, fault_injection_control, arr_flip, exp_q[$];
  logic [3:0] arr_write = 4'h0, rd = 4'h0, ds, dd;
  logic [5:0] corr_event, det_single, det_double;
  logic [1:0] x45 = 2'h0;
  int failures = 0, checks_done = 0, cyc = 0;
  assign det_single = {2'h0, ds};
  assign det_double = {x45, dd};
  always #25 clk = ~clk;
  ecc_control dut (.*);
  ecc_ram_model ram (.clk(clk), .wr(arr_write), .rd(rd), .flip(arr_flip), .ds(ds), .dd(dd));
  task automatic check(string n, logic [7:0] e, logic [7:0] s);
    checks_done++;
    if (s !== e) begin
      failures++;
      $display("[ERR] %s exp %h saw %h", n, e, s);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      failures++;
      tally_and_finish();
    end
  end
  always @(negedge clk) begin
    if (rst_b && (ecc_exception || handler_loop_event || corr_event != 6'h0)) begin
      check("event", exp_q.size() > 0 ? exp_q.pop_front() : 8'h0, {ecc_exception, handler_loop_event, corr_event});
    end
  end
  initial begin
    int t;
    logic [1:0] m, xx;
    logic en, d, s;
    void'($urandom(59955));
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    @(negedge clk);
    check("reset", 8'h0, fault_injection_control | 8'(code_check_enable_bit));
    for (int i = 0; i < 48; i++) begin
      t = $urandom % 4;
      m = 2'($urandom % 2 + 1);
      en = 1'($urandom);
      xx = 2'($urandom);
      @(posedge clk);
      {cfg_wr, cfg_wdata, inj_wr, icache_line_valid, in_handler} <= {1'b1, en, 1'b1, 2'($urandom)};
      inj_wdata <= 8'(m) << 2 * t;
      @(posedge clk);
      {cfg_wr, inj_wr} <= 2'h0;
      arr_write <= 4'h1 << t;
      @(negedge clk);
      check("field", 8'(m), (fault_injection_control >> 2 * t) & 8'h3);
      check("flip", {6'h0, m[1], 1'b1}, (arr_flip >> 2 * t) & 8'h3);
      @(posedge clk);
      arr_write <= 4'h0;
      rd <= 4'h1 << t;
      @(negedge clk);
      check("clear", 8'h0, (fault_injection_control >> 2 * t) & 8'h3);
      @(posedge clk);
      rd <= 4'h0;
      x45 <= xx;
      d = en && (m[1] && (t != 0 || icache_line_valid) || xx != 2'h0);
      s = en && m[0] && (t != 0 || icache_line_valid);
      if (d || s) exp_q.push_back({d, d && in_handler, 6'(s) << t});
      @(posedge clk);
      x45 <= 2'h0;
      repeat (2) @(posedge clk);
    end
    $display("random injection test done");
    check("drain", 8'h0, 8'(exp_q.size()));
    tally_and_finish();
  end
endmodule

// >>> test/ecc_ram_model.sv
// =====
// Protected arrays
module ecc_ram_model (
  input wire logic clk,
  input wire logic [3:0] wr, rd,
  input wire logic [7:0] flip,
  output logic [3:0] ds = 4'h0, dd = 4'h0
);
  timeunit 1ns;
  timeprecision 1ns;
  // Flipped bits persist until the word is rewritten
  logic [7:0] err = 8'h0;
  always @(posedge clk) begin
    for (int t = 0; t < 4; t++) begin
      if (wr[t]) err[2*t+:2] <= flip[2*t+:2];
      ds[t] <= rd[t] && err[2*t+:2] == 2'h1;
      dd[t] <= rd[t] && err[2*t+:2] == 2'h3;
    end
  end
endmodule
